/* hdl/pio_pins.sv */
// Multipurpose pin control: two two-way pins and one output pin
// Assumes pins are asynchronous and registers reached by plain port
//
// Chosen here: the address map and strobed register access.
`include "pio_consts.svh"
module pio_pins (
  input  wire logic       clock,
  input  wire logic       nrst,
  input  wire logic       clk_en,
  input  wire logic [3:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_write,
  input  wire logic       reg_read,
  output logic      [7:0] reg_rdata,
  input  wire logic       power_good,
  input  wire logic       seq_pin1_low,
  input  wire logic       seq_pin3_low,
  input  wire logic       first_io_pin_in,
  output logic            first_io_pin_out,
  output logic            first_io_pin_oe,
  output logic            second_output_pin_out,
  output logic            second_output_pin_oe,
  input  wire logic       third_io_pin_in,
  output logic            third_io_pin_out,
  output logic            third_io_pin_oe,
  output logic            buck12_default_restore
);
  import pio_pkg::*;
  pio_sync_if sif ();
  logic [7:0]      ctrl;
  logic [7:0]      next_ctrl;
  logic [7:0]      rdata;
  logic [7:0]      next_rdata;
  pio_out2_state_t state;
  pio_out2_state_t next_state;
  logic            held;
  logic            next_held;
  logic            pin3_d;
  logic            next_pin3_d;
  logic            restore;
  logic            next_restore;
  logic            out2_drive;
  logic            out2_level;
  logic            out2_q;
  logic            next_out2_q;
  logic            oe2_q;
  logic            next_oe2_q;
  logic            pin1_s;
  logic            pg_s;
  logic            pin3_s;
  logic            pin1_reset_input_select;
  logic            pin1_user_out_bit;
  logic            out2_user_bit;
  logic            out2_driver_type;
  logic            pin3_user_out_bit;
  logic            buck12_reset_enable;

  assign sif.raw = {third_io_pin_in, power_good, first_io_pin_in};
  pio_sync u_sync (
    .clock  (clock),
    .nrst   (nrst),
    .clk_en (clk_en),
    .sif    (sif)
  );
  assign pin1_s = sif.synced[0];
  assign pg_s   = sif.synced[1];
  assign pin3_s = sif.synced[2];

  assign pin1_reset_input_select = ctrl[`PIO_BIT_P1_SEL];
  assign pin1_user_out_bit       = ctrl[`PIO_BIT_P1_OUT];
  assign out2_user_bit           = ctrl[`PIO_BIT_OUT2_BIT];
  assign out2_driver_type        = ctrl[`PIO_BIT_OUT2_DRV];
  assign pin3_user_out_bit       = ctrl[`PIO_BIT_P3_OUT];
  assign buck12_reset_enable     = ctrl[`PIO_BIT_B12_EN];

  // Register port
  always_comb
  begin
    next_ctrl  = ctrl;
    next_rdata = 8'h00;
    if (clk_en && reg_write && reg_addr == `PIO_ADDR_CTRL)
      next_ctrl = {2'h0, reg_wdata[5:0]};
    if (clk_en && reg_read)
    begin
      case (reg_addr)
        `PIO_ADDR_CTRL:   next_rdata = ctrl;
        `PIO_ADDR_STATUS: next_rdata = {4'h0, pin3_s, pg_s, pin1_s,
                                        second_output_pin_out};
        default:          next_rdata = 8'h00;
      endcase
    end
    else if (!clk_en)
      next_rdata = rdata;
  end

  // Second output source when first pin is a reset input
  always_comb
  begin
    next_state = state;
    next_held  = held;
    if (clk_en)
    begin
      case (state)
        PIO_OUT2_POR:
        begin
          next_held = 1'b0;
          if (pg_s)
            next_state = PIO_OUT2_PASS;
        end
        PIO_OUT2_PASS:
        begin
          next_held = pin1_s;
          if (!pg_s)
            next_state = PIO_OUT2_HOLD;
        end
        PIO_OUT2_HOLD:
        begin
          if (pg_s)
          begin
            next_state = PIO_OUT2_PASS;
            next_held  = pin1_s;
          end
        end
        default:
        begin
          next_state = PIO_OUT2_POR;
          next_held  = 1'b0;
        end
      endcase
    end
  end

  always_comb
  begin
    if (pin1_reset_input_select)
    begin
      if (state == PIO_OUT2_PASS && pg_s)
        out2_level = pin1_s;
      else
        out2_level = held;
    end
    else
      out2_level = out2_user_bit;
    out2_drive  = out2_driver_type | ~out2_level;
    next_out2_q = clk_en ? (out2_level & out2_driver_type) : out2_q;
    next_oe2_q  = clk_en ? out2_drive : oe2_q;
  end

  // Converter reset edge detect
  always_comb
  begin
    next_restore = restore;
    next_pin3_d  = pin3_d;
    if (clk_en)
    begin
      next_restore = buck12_reset_enable & pin3_d & ~pin3_s;
      next_pin3_d  = pin3_s;
    end
  end

  // Register port state
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      ctrl  <= `PIO_CTRL_RESET;
      rdata <= 8'h00;
    end
    else
    begin
      ctrl  <= next_ctrl;
      rdata <= next_rdata;
    end
  end

  // Second output source state
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      state <= PIO_OUT2_POR;
      held  <= `PIO_POR_LOW_VALUE;
    end
    else
    begin
      state <= next_state;
      held  <= next_held;
    end
  end

  // Second output pin driver
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      out2_q <= 1'b0;
      oe2_q  <= 1'b1;
    end
    else
    begin
      out2_q <= next_out2_q;
      oe2_q  <= next_oe2_q;
    end
  end

  // Edge history matches the synchroniser reset, so no false edge
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      pin3_d  <= 1'b0;
      restore <= 1'b0;
    end
    else
    begin
      pin3_d  <= next_pin3_d;
      restore <= next_restore;
    end
  end

  assign reg_rdata              = rdata;
  assign second_output_pin_out  = out2_q;
  assign second_output_pin_oe   = oe2_q;
  assign buck12_default_restore = restore;
  assign first_io_pin_out = 1'b0;
  assign first_io_pin_oe  = ~pin1_reset_input_select &
                            (~pin1_user_out_bit | seq_pin1_low);
  assign third_io_pin_out = 1'b0;
  assign third_io_pin_oe  = ~buck12_reset_enable &
                            (~pin3_user_out_bit | seq_pin3_low);

  AST_PASS: assert property (@(posedge clock) disable iff (!nrst)
    clk_en && pin1_reset_input_select && state == PIO_OUT2_PASS && pg_s
    |=> second_output_pin_out == $past(out2_driver_type & pin1_s))
    else $error("pass-through level wrong");
  AST_POR_LOW: assert property (@(posedge clock) disable iff (!nrst)
    state == PIO_OUT2_POR && pin1_reset_input_select && clk_en
    |=> !second_output_pin_out && second_output_pin_oe)
    else $error("second output not low after reset");
  AST_HOLD: assert property (@(posedge clock) disable iff (!nrst)
    state == PIO_OUT2_HOLD && $past(state) == PIO_OUT2_HOLD && clk_en
    |-> $stable(held))
    else $error("latched level changed");
  AST_OD2: assert property (@(posedge clock) disable iff (!nrst)
    clk_en && !out2_driver_type |=> !second_output_pin_out)
    else $error("open drain drives high");
  AST_PP2: assert property (@(posedge clock) disable iff (!nrst)
    clk_en && out2_driver_type |=> second_output_pin_oe)
    else $error("push-pull released");
  AST_USER2: assert property (@(posedge clock) disable iff (!nrst)
    clk_en && !pin1_reset_input_select && !out2_driver_type
    |=> second_output_pin_oe == !$past(out2_user_bit))
    else $error("user bit not followed");
  AST_PIN1: assert property (@(posedge clock) disable iff (!nrst)
    pin1_reset_input_select |-> !first_io_pin_oe)
    else $error("first pin driven in input mode");
  AST_PIN3: assert property (@(posedge clock) disable iff (!nrst)
    !buck12_reset_enable && !pin3_user_out_bit |-> third_io_pin_oe)
    else $error("third pin not low");
  AST_RST: assert property (@(posedge clock) disable iff (!nrst)
    clk_en && buck12_reset_enable && pin3_d && !pin3_s
    |=> buck12_default_restore)
    else $error("converter restore missing");
  AST_SEL2: assert property (@(posedge clock) disable iff (!nrst)
    clk_en && pin1_reset_input_select && state == PIO_OUT2_PASS && pg_s &&
    !out2_driver_type |=> second_output_pin_oe == !$past(pin1_s))
    else $error("open drain not following first pin");
  AST_LATCH: assert property (@(posedge clock) disable iff (!nrst)
    clk_en && pin1_reset_input_select && state == PIO_OUT2_HOLD
    |=> second_output_pin_out == $past(out2_driver_type & held))
    else $error("second output not from latched level");
  AST_POR_HELD: assert property (@(posedge clock) disable iff (!nrst)
    state == PIO_OUT2_POR |-> !held)
    else $error("level not low after reset");
  AST_PIN1_OD: assert property (@(posedge clock) disable iff (!nrst)
    !pin1_reset_input_select && !pin1_user_out_bit |-> first_io_pin_oe)
    else $error("first pin not low");
  AST_OUT_LOW: assert property (@(posedge clock) disable iff (!nrst)
    !first_io_pin_out && !third_io_pin_out)
    else $error("open drain pin driven high");
  AST_PIN3_IN: assert property (@(posedge clock) disable iff (!nrst)
    buck12_reset_enable |-> !third_io_pin_oe)
    else $error("third pin driven in reset mode");
  AST_NO_RST: assert property (@(posedge clock) disable iff (!nrst)
    clk_en && !buck12_reset_enable |=> !buck12_default_restore)
    else $error("converter restore while disabled");
  AST_SYNC: assert property (@(posedge clock) disable iff (!nrst)
    clk_en && $past(clk_en) && $past(nrst)
    |=> pin1_s == $past(first_io_pin_in, 2) && pg_s == $past(power_good, 2))
    else $error("synchronised input wrong");
  COV_PASS: cover property (@(posedge clock) state == PIO_OUT2_PASS);
  COV_HOLD: cover property (@(posedge clock) state == PIO_OUT2_HOLD);
  COV_RST: cover property (@(posedge clock) buck12_default_restore);
  COV_POR_SEL: cover property (@(posedge clock)
    pin1_reset_input_select && state == PIO_OUT2_POR);
endmodule : pio_pins

/* shared/pio_consts.svh */
// Constants for the multipurpose pin block
// Assumes inclusion by bare name from any design file
`ifndef PIO_CONSTS_SVH
`define PIO_CONSTS_SVH
`define PIO_ADDR_CTRL      4'h0
`define PIO_ADDR_STATUS    4'h1
`define PIO_ADDR_STROBE    4'h2
`define PIO_BIT_P1_SEL     0
`define PIO_BIT_P1_OUT     1
`define PIO_BIT_OUT2_BIT   2
`define PIO_BIT_OUT2_DRV   3
`define PIO_BIT_P3_OUT     4
`define PIO_BIT_B12_EN     5
`define PIO_CTRL_RESET     8'h12
`define PIO_SYNC_STAGES    2
`define PIO_POR_LOW_VALUE  1'b0
`endif

/* shared/pio_pkg.sv */
// Types for the multipurpose pin block
// Assumes pio_consts.svh sits beside it
package pio_pkg;
  typedef enum logic [1:0] {
    PIO_OUT2_POR,
    PIO_OUT2_PASS,
    PIO_OUT2_HOLD
  } pio_out2_state_t;
endpackage : pio_pkg

/* shared/pio_sync_if.sv */
// Carrier between the top module and its synchroniser
// Assumes one clock shared by both ends
interface pio_sync_if;
  logic [2:0] raw;
  logic [2:0] synced;
  modport top  (output raw, input synced);
  modport sync (input raw, output synced);
endinterface : pio_sync_if

/* hdl/pio_sync.sv */
// Two-stage synchroniser for the pin inputs
// Assumes inputs are asynchronous to clock
module pio_sync (
  input  wire logic clock,
  input  wire logic nrst,
  input  wire logic clk_en,
  pio_sync_if.sync  sif
);
  import pio_pkg::*;
  logic [2:0] stage1;
  logic [2:0] stage2;
  logic [2:0] next_stage1;
  logic [2:0] next_stage2;
  always_comb
  begin
    next_stage1 = clk_en ? sif.raw : stage1;
    next_stage2 = clk_en ? stage1 : stage2;
  end
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      stage1 <= 3'h0;
      stage2 <= 3'h0;
    end
    else
    begin
      stage1 <= next_stage1;
      stage2 <= next_stage2;
    end
  end
  assign sif.synced = stage2;
endmodule : pio_sync

/* verification/pio_host_model.sv */
// Host processor and memory reset line facing the three pins
// Assumes pull-ups on all three lines; open drain wins low
module pio_host_model (
  input  wire logic host_pin1_low,
  input  wire logic host_pin3_low,
  input  wire logic pin1_oe,
  input  wire logic pin3_oe,
  input  wire logic out2_out,
  input  wire logic out2_oe,
  output logic      pin1_level,
  output logic      pin3_level,
  output logic      out2_level
);
  timeunit 1ns;
  timeprecision 1ps;
  // Host drives memory reset request on the first pin
  assign pin1_level = !(pin1_oe || host_pin1_low);
  assign pin3_level = !(pin3_oe || host_pin3_low);
  assign out2_level = out2_oe ? out2_out : 1'b1;
endmodule : pio_host_model

/* verification/pio_pins_tb.sv */
// Self-checking bench for the multipurpose pin block
// Assumes the host model resolves the shared pin lines
`include "pio_consts.svh"
module pio_pins_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clock = 0, nrst = 0, clk_en = 1;
  logic        reg_write = 0, reg_read = 0, rd_pend = 0, pin_chk = 0;
  logic [3:0]  reg_addr = 4'h0;
  logic [7:0]  reg_wdata = 8'h00, reg_rdata;
  logic        power_good = 0, seq1 = 0, seq3 = 0, h1 = 0, h3 = 0;
  logic        p1_oe, p3_oe, o2_out, o2_oe, lv1, lv3, lv2, restore;
  logic [7:0]  exp_q[$], pin_q[$];
  int          err_count = 0, compares = 0, pulses = 0, p0;
  logic [31:0] rng = 32'h0000c60d;
  always #2.5 clock = ~clock;
  pio_pins pio_pins_inst (.clock(clock), .nrst(nrst), .clk_en(clk_en),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
    .reg_read(reg_read), .reg_rdata(reg_rdata), .power_good(power_good),
    .seq_pin1_low(seq1), .seq_pin3_low(seq3), .first_io_pin_in(lv1),
    .first_io_pin_out(), .first_io_pin_oe(p1_oe),
    .second_output_pin_out(o2_out), .second_output_pin_oe(o2_oe),
    .third_io_pin_in(lv3), .third_io_pin_out(), .third_io_pin_oe(p3_oe),
    .buck12_default_restore(restore));
  pio_host_model pio_host_model_inst (.host_pin1_low(h1),
    .host_pin3_low(h3), .pin1_oe(p1_oe), .pin3_oe(p3_oe),
    .out2_out(o2_out), .out2_oe(o2_oe), .pin1_level(lv1),
    .pin3_level(lv3), .out2_level(lv2));
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction : xs
  task automatic check(input logic [7:0] e, input logic [7:0] g);
    compares++;
    if (g !== e)
    begin
      err_count++;
      $display("wrong value at %0t: expected %h got %h", $time, e, g);
    end
  endtask : check
  task automatic end_of_test();
    $display("compares %0d err_count %0d", compares, err_count);
    if (err_count == 0 && compares > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : end_of_test
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clock);
    reg_write <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clock);
    reg_read <= 1'b0;
    @(posedge clock);
  endtask : rd
  task automatic pins(input logic [3:0] e);
    pin_q.push_back({4'h0, e});
    repeat (5) @(posedge clock);
    pin_chk <= 1'b1;
    @(posedge clock);
    pin_chk <= 1'b0;
  endtask : pins
  // Read results are compared against the oldest note
  always @(posedge clock)
  begin
    rd_pend <= reg_read;
    if (restore === 1'b1)
      pulses <= pulses + 1;
  end
  always @(negedge clock)
    if (rd_pend)
      check(exp_q.pop_front(), reg_rdata);
  // Pin states are compared against the oldest pin note
  always @(negedge clock)
    if (pin_chk)
      check(pin_q.pop_front(), {4'h0, p1_oe, p3_oe, o2_oe, lv2});
  initial
  begin
    repeat (20000) @(posedge clock);
    err_count++;
    end_of_test();
  end
  initial
  begin
    repeat (16) @(posedge clock);
    nrst <= 1'b1;
    @(posedge clock);
    rd(4'h0, `PIO_CTRL_RESET);
    pins(4'b0010);
    $display("test reset done");
    for (int i = 0; i < 16; i++)
    begin
      rng = xs(rng);
      seq1 <= rng[0];
      seq3 <= rng[1];
      wr(4'h0, {3'h0, i[3:0], 1'b0});
      rd(4'h0, {3'h0, i[3:0], 1'b0});
      pins({!i[0] | rng[0], !i[3] | rng[1], i[2] | !i[1], i[1]});
    end
    $display("test user bits done");
    seq1 <= 1'b1;
    seq3 <= 1'b0;
    wr(4'h0, 8'h19);
    pins(4'b0010);
    power_good <= 1'b1;
    pins(4'b0011);
    h1 <= 1'b1;
    pins(4'b0010);
    h1 <= 1'b0;
    wr(4'h0, 8'h11);
    pins(4'b0001);
    wr(4'h0, 8'h19);
    power_good <= 1'b0;
    pins(4'b0011);
    h1 <= 1'b1;
    pins(4'b0011);
    rd(4'h1, {4'h0, lv3, 1'b0, lv1, 1'b1});
    power_good <= 1'b1;
    pins(4'b0010);
    power_good <= 1'b0;
    pins(4'b0010);
    h1 <= 1'b0;
    pins(4'b0010);
    $display("test memory reset done");
    seq3 <= 1'b1;
    wr(4'h0, 8'h21);
    pins(4'b0010);
    p0 = pulses;
    h3 <= 1'b1;
    repeat (10) @(posedge clock);
    check(8'h01, 8'(pulses - p0));
    h3 <= 1'b0;
    wr(4'h0, 8'h11);
    p0 = pulses;
    h3 <= 1'b1;
    repeat (10) @(posedge clock);
    check(8'h00, 8'(pulses - p0));
    $display("test converter reset done");
    clk_en <= 1'b0;
    power_good <= 1'b1;
    wr(4'h0, 8'h00);
    pins(4'b0110);
    clk_en <= 1'b1;
    rd(4'h0, 8'h11);
    pins(4'b0101);
    $display("test clock enable done");
    wr(4'h2, 8'h3f);
    rd(4'h0, 8'h11);
    rd(4'h5, 8'h00);
    $display("test unmapped done");
    end_of_test();
  end
endmodule : pio_pins_tb
